/* File: logic/yrc_pkg.sv */
// yrc_pkg: constants, carriers and state types of the year and real-time counters
package yrc_pkg;

  // widths
  localparam int COUNT_W  = 32;
  localparam int TRIM_W   = 16;
  localparam int ADDR_W   = 8;
  localparam int MATCH_N  = 3;

  // timebase figures
  localparam int SLOW_CLOCK_HZ = 32768;
  localparam int CLOCK_HZ      = 25000000;

  // byte offsets of the register window
  localparam logic [ADDR_W-1:0] OFS_YEAR_TRIM     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_YEAR_LOAD     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_YEAR_MATCH_0  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_YEAR_MATCH_1  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_YEAR_MATCH_2  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_YEAR_COUNT    = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_RT_TRIM       = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_RT_LOAD       = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_RT_MATCH_0    = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_RT_MATCH_1    = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_RT_MATCH_2    = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_RT_COUNT      = 8'h58;

  // offsets inside one counter's group, relative to its trim register
  localparam logic [ADDR_W-1:0] REL_TRIM    = 8'h00;
  localparam logic [ADDR_W-1:0] REL_LOAD    = 8'h04;
  localparam logic [ADDR_W-1:0] REL_MATCH_0 = 8'h08;
  localparam logic [ADDR_W-1:0] REL_MATCH_2 = 8'h10;

  // control/status bit positions
  localparam int BIT_YEAR_TRIM_PEND  = 0;
  localparam int BIT_YEAR_LOAD_PEND  = 1;
  localparam int BIT_YEAR_MATCH_PEND = 2;   // bits 4:2
  localparam int BIT_RT_LOAD_PEND    = 16;
  localparam int BIT_RT_MATCH_PEND   = 17;  // bits 19:17
  localparam int BIT_RT_TRIM_PEND    = 20;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                awvalid;
    logic [ADDR_W-1:0]   awaddr;
    logic                wvalid;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bready;
    logic                arvalid;
    logic [ADDR_W-1:0]   araddr;
    logic                rready;
  } yrc_axi_req_t;

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } yrc_axi_rsp_t;

  typedef struct packed {
    logic [MATCH_N-1:0]  match;
    logic                tick;
  } yrc_events_t;

  typedef struct packed {
    logic [TRIM_W-1:0]                 div;
    logic [TRIM_W-1:0]                 trim;
    logic [TRIM_W-1:0]                 trimStage;
    logic [COUNT_W-1:0]                load;
    logic [COUNT_W-1:0]                count;
    logic [MATCH_N-1:0][COUNT_W-1:0]   match;
    logic [MATCH_N-1:0][COUNT_W-1:0]   matchStage;
    logic                              trimPend;
    logic                              loadPend;
    logic [MATCH_N-1:0]                matchPend;
    logic                              tick;
    logic [MATCH_N-1:0]                hit;
  } yrc_ctr_t;

  typedef struct packed {
    logic                slowSync1;
    logic                slowSync2;
    logic                slowPrev;
    yrc_ctr_t            yearCtr;
    yrc_ctr_t            rtCtr;
    logic                awHeld;
    logic                wHeld;
    logic [ADDR_W-1:0]   awAddr;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } yrc_state_t;

  localparam yrc_state_t STATE_RESET = '0;

endpackage

/* File: logic/yrc_counters.sv */
// yrc_counters: year and real-time counters with an AXI4-Lite register window
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps

module yrc_counters
  import yrc_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  // slow timebase pin and power state
  input  wire logic                    slowClockIn,
  input  wire logic                    sleep,
  // register bus
  input  wire yrc_pkg::yrc_axi_req_t   axiReq,
  output      yrc_pkg::yrc_axi_rsp_t   axiRsp,
  // events toward the interrupt controller and power manager
  output      yrc_pkg::yrc_events_t    yearEvents,
  output      yrc_pkg::yrc_events_t    rtEvents,
  output      logic                    wakeRequest
);
  import yrc_pkg::*;

  yrc_state_t q;
  yrc_state_t d;
  logic       slowEdge;

  // byte-lane merge of a write
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // one slow-clock step of a counter
  function automatic yrc_ctr_t ctr_step(input yrc_ctr_t c,
                                        input logic     edgeSeen,
                                        input logic     run);
    yrc_ctr_t n;
    n = c;
    n.tick = 1'b0;
    n.hit = '0;
    if (edgeSeen && run)
    begin
      if (c.div >= c.trim)
      begin
        n.div = '0;
        n.tick = 1'b1;
        n.count = c.loadPend ? c.load : c.count + 32'h1;
        n.trim = c.trimPend ? c.trimStage : c.trim;
        n.trimPend = 1'b0;
        n.loadPend = 1'b0;
        for (int i = 0; i < MATCH_N; i++)
        begin
          n.match[i] = c.matchPend[i] ? c.matchStage[i] : c.match[i];
          n.matchPend[i] = 1'b0;
          n.hit[i] = (n.count == n.match[i]);
        end
      end
      else
      begin
        n.div = c.div + 16'h1;
      end
    end
    return n;
  endfunction

  // software write into a counter group; setting pending wins over clearing
  function automatic yrc_ctr_t ctr_write(input yrc_ctr_t          c,
                                         input logic [ADDR_W-1:0] rel,
                                         input logic [31:0]       data,
                                         input logic [3:0]        strb);
    yrc_ctr_t    n;
    logic [31:0] w;
    int          idx;
    n = c;
    w = '0;
    idx = 0;
    if (rel == REL_TRIM)
    begin
      w = merge_bytes({16'h0, c.trimStage}, data, strb);
      n.trimStage = w[TRIM_W-1:0];
      n.trimPend = 1'b1;
    end
    else if (rel == REL_LOAD)
    begin
      n.load = merge_bytes(c.load, data, strb);
      n.loadPend = 1'b1;
    end
    else if (rel >= REL_MATCH_0 && rel <= REL_MATCH_2)
    begin
      idx = int'((rel - REL_MATCH_0) >> 2);
      n.matchStage[idx] = merge_bytes(c.matchStage[idx], data, strb);
      n.matchPend[idx] = 1'b1;
    end
    return n;
  endfunction

  // software read of a counter group
  function automatic logic [31:0] ctr_read(input yrc_ctr_t          c,
                                           input logic [ADDR_W-1:0] rel);
    logic [31:0] r;
    int          idx;
    r = '0;
    idx = 0;
    if (rel == REL_TRIM)
    begin
      r = {16'h0, c.trimStage};
    end
    else if (rel >= REL_MATCH_0 && rel <= REL_MATCH_2)
    begin
      idx = int'((rel - REL_MATCH_0) >> 2);
      r = c.matchStage[idx];
    end
    return r;
  endfunction

  // word address belongs to a counter group starting at base
  function automatic logic in_group(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] base);
    return addr[1:0] == 2'h0 && addr >= base && addr <= base + REL_MATCH_2;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return in_group(addr, OFS_YEAR_TRIM) || in_group(addr, OFS_RT_TRIM) ||
           addr == OFS_CTRL_STATUS || addr == OFS_YEAR_COUNT ||
           addr == OFS_RT_COUNT;
  endfunction

  function automatic logic [31:0] ctrl_status(input yrc_ctr_t y,
                                              input yrc_ctr_t r);
    logic [31:0] s;
    s = '0;
    s[BIT_YEAR_TRIM_PEND] = y.trimPend;
    s[BIT_YEAR_LOAD_PEND] = y.loadPend;
    s[BIT_YEAR_MATCH_PEND +: MATCH_N] = y.matchPend;
    s[BIT_RT_LOAD_PEND] = r.loadPend;
    s[BIT_RT_MATCH_PEND +: MATCH_N] = r.matchPend;
    s[BIT_RT_TRIM_PEND] = r.trimPend;
    return s;
  endfunction

  // rising edge of the slow clock, seen only past the synchroniser
  assign slowEdge = q.slowSync2 & ~q.slowPrev;

  // handshake outputs
  always_comb
  begin
    axiRsp.awready = ~q.awHeld & ~q.bvalid;
    axiRsp.wready = ~q.wHeld & ~q.bvalid;
    axiRsp.bvalid = q.bvalid;
    axiRsp.bresp = q.bresp;
    axiRsp.arready = ~q.rvalid;
    axiRsp.rvalid = q.rvalid;
    axiRsp.rdata = q.rdata;
    axiRsp.rresp = q.rresp;
  end

  // events, all from flip-flops
  always_comb
  begin
    yearEvents.tick = q.yearCtr.tick;
    yearEvents.match = q.yearCtr.hit;
    rtEvents.tick = q.rtCtr.tick;
    rtEvents.match = q.rtCtr.hit;
    wakeRequest = q.yearCtr.hit[2];
  end

  always_comb
  begin
    d = q;
    d.slowSync1 = slowClockIn;
    d.slowSync2 = q.slowSync1;
    d.slowPrev = q.slowSync2;

    // same step for both; only the run condition differs
    d.yearCtr = ctr_step(q.yearCtr, slowEdge, 1'b1);
    d.rtCtr = ctr_step(q.rtCtr, slowEdge, ~sleep);

    // write address and data, taken in either order
    if (axiReq.awvalid && axiRsp.awready)
    begin
      d.awHeld = 1'b1;
      d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready)
    begin
      d.wHeld = 1'b1;
      d.wData = axiReq.wdata;
      d.wStrb = axiReq.wstrb;
    end
    if (q.awHeld && q.wHeld)
    begin
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (in_group(q.awAddr, OFS_YEAR_TRIM))
      begin
        d.yearCtr = ctr_write(d.yearCtr, q.awAddr - OFS_YEAR_TRIM, q.wData, q.wStrb);
      end
      else if (in_group(q.awAddr, OFS_RT_TRIM))
      begin
        d.rtCtr = ctr_write(d.rtCtr, q.awAddr - OFS_RT_TRIM, q.wData, q.wStrb);
      end
    end
    if (q.bvalid && axiReq.bready)
    begin
      d.bvalid = 1'b0;
    end

    // read channel
    if (axiReq.arvalid && axiRsp.arready)
    begin
      d.rvalid = 1'b1;
      d.rresp = is_mapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
      d.rdata = '0;
      if (in_group(axiReq.araddr, OFS_YEAR_TRIM))
      begin
        d.rdata = ctr_read(q.yearCtr, axiReq.araddr - OFS_YEAR_TRIM);
      end
      else if (in_group(axiReq.araddr, OFS_RT_TRIM))
      begin
        d.rdata = ctr_read(q.rtCtr, axiReq.araddr - OFS_RT_TRIM);
      end
      else if (axiReq.araddr == OFS_CTRL_STATUS)
      begin
        d.rdata = ctrl_status(q.yearCtr, q.rtCtr);
      end
      else if (axiReq.araddr == OFS_YEAR_COUNT)
      begin
        d.rdata = q.yearCtr.count;
      end
      else if (axiReq.araddr == OFS_RT_COUNT)
      begin
        d.rdata = q.rtCtr.count;
      end
    end
    else if (q.rvalid && axiReq.rready)
    begin
      d.rvalid = 1'b0;
    end
  end

  // sleep does not touch the state, so settings survive it
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      q <= STATE_RESET;
    end
    else
    begin
      q <= d;
    end
  end

endmodule // yrc_counters

/* File: bench/yrc_counters_assertions.sv */
// yrc_counters_assertions: bus and event timing checks of the counters
`timescale 1ns/1ps
module yrc_counters_assertions
  import yrc_pkg::*;
(
  // clock, reset, power state
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire logic                  sleep,
  // bus and events
  input wire yrc_pkg::yrc_axi_req_t axiReq,
  input wire yrc_pkg::yrc_axi_rsp_t axiRsp,
  input wire yrc_pkg::yrc_events_t  yearEvents,
  input wire yrc_pkg::yrc_events_t  rtEvents,
  input wire logic                  wakeRequest
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence sWrTaken;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  sequence sRdTaken;
    axiReq.arvalid && axiRsp.arready;
  endsequence
  AST_WR_ANSWER: assert property (sWrTaken |-> ##[1:2] axiRsp.bvalid)
    else $error("write answer missing");
  AST_WR_HOLD: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid)
    else $error("write answer dropped");
  AST_RD_ANSWER: assert property (sRdTaken |=> axiRsp.rvalid && !axiRsp.arready)
    else $error("read answer missing");
  AST_RD_HOLD: assert property (axiRsp.rvalid && !axiReq.rready |=> $stable(axiRsp.rdata))
    else $error("read data changed");
  AST_SLVERR_ZERO: assert property (axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR
    |-> axiRsp.rdata == 32'h0) else $error("refused read not zero");
  AST_TICK_PULSE: assert property (yearEvents.tick |=> !yearEvents.tick [*8])
    else $error("year tick too long");
  AST_YEAR_MATCH: assert property (|yearEvents.match |-> yearEvents.tick)
    else $error("year match off tick");
  AST_RT_MATCH: assert property (|rtEvents.match |-> rtEvents.tick)
    else $error("rt match off tick");
  AST_RT_SLEEP: assert property (sleep |=> !rtEvents.tick)
    else $error("rt ticked asleep");
  AST_WAKE: assert property (wakeRequest == yearEvents.match[2])
    else $error("wake differs from match 2");
endmodule // yrc_counters_assertions

bind yrc_counters yrc_counters_assertions i_yrc_counters_assertions (
  .clock(clock), .reset_n(reset_n), .sleep(sleep), .axiReq(axiReq), .axiRsp(axiRsp),
  .yearEvents(yearEvents), .rtEvents(rtEvents), .wakeRequest(wakeRequest));

/* File: bench/yrc_counters_test.sv */
// yrc_counters_test: self-checking bench of the counters
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module yrc_counters_test;
  import yrc_pkg::*;
  logic         clock = 1'b0;
  logic         reset_n;
  logic         slowClockIn = 1'b0;
  logic [9:0]   slowCnt = '0;
  logic         sleep;
  logic         wakeRequest;
  logic         wk;
  yrc_axi_req_t axiReq;
  yrc_axi_rsp_t axiRsp;
  yrc_events_t  yearEvents;
  yrc_events_t  rtEvents;
  logic [2:0]   mt;
  logic [3:0]   rtSeen;
  logic [1:0]   rsp;
  logic [31:0]  rd, c0, y0;
  int           errors, total_checks, slowEdges, e0;
  // rows: address and written value; first six read back whole, last two refused
  localparam logic [7:0] TA [12] = '{8'h08, 8'h0C, 8'h10, 8'h4C, 8'h50, 8'h54,
    8'h00, 8'h44, 8'h04, 8'h48, 8'h60, 8'h02};
  localparam logic [31:0] TD [12] = '{32'hA5A5_0001, 32'h5A5A_0002, 32'h0F0F_0003,
    32'hF0F0_0004, 32'h1234_5678, 32'h8765_4321, 32'hFFFF_0000, 32'hFFFF_0000,
    32'h0, 32'h0, 32'hDEAD_BEEF, 32'hDEAD_BEEF};
  // match pattern on the ticks after the matches are set
  localparam logic [2:0] MX [4] = '{3'h0, 3'h1, 3'h6, 3'h0};
  localparam logic [2:0] MR [4] = '{3'h0, 3'h1, 3'h0, 3'h0};

  yrc_counters i_yrc_counters (
    .clock(clock), .reset_n(reset_n), .slowClockIn(slowClockIn), .sleep(sleep),
    .axiReq(axiReq), .axiRsp(axiRsp), .yearEvents(yearEvents), .rtEvents(rtEvents),
    .wakeRequest(wakeRequest));

  always #20ns clock = ~clock;
  // slow pin: half periods of 381 and 382 clocks, close to 32.768 kHz
  always @(posedge clock)
  begin
    slowCnt <= (slowCnt == 10'h2FA) ? 10'h000 : slowCnt + 10'h001;
    if (slowCnt == 10'h17C || slowCnt == 10'h2FA)
      slowClockIn <= ~slowClockIn;
  end
  always @(posedge slowClockIn) slowEdges++;

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    do
    begin
      @(posedge clock);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid && !axiReq.bready) axiReq.bready <= 1'b1;
    end
    while (!(axiRsp.bvalid && axiReq.bready));
    rsp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    do
    begin
      @(posedge clock);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid && !axiReq.rready) axiReq.rready <= 1'b1;
    end
    while (!(axiRsp.rvalid && axiReq.rready));
    rd = axiRsp.rdata;
    rsp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axiWrite(a, d);
    `CHK($sformatf("bresp %h", a), RESP_OKAY, rsp);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    axiRead(a);
    `CHK($sformatf("rresp %h", a), RESP_OKAY, rsp);
    `CHK($sformatf("rdata %h", a), e, rd);
  endtask

  task automatic waitTick();
    do
      @(posedge clock);
    while (yearEvents.tick !== 1'b1);
    mt = yearEvents.match;
    wk = wakeRequest;
    rtSeen = rtEvents;
  endtask

  initial
  begin
    repeat (60000) @(posedge clock);
    errors++;
    summarize();
  end

  initial
  begin
    reset_n = 1'b0;
    sleep = 1'b0;
    axiReq = '0;
    axiReq.wstrb = 4'hF;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    `CHK("awready", 1'b1, axiRsp.awready);
    rdChk(OFS_CTRL_STATUS, 32'h0);
    rdChk(OFS_YEAR_COUNT, 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      axiWrite(TA[i], TD[i]);
      `CHK("bresp", (i < 10) ? RESP_OKAY : RESP_SLVERR, rsp);
      axiRead(TA[i]);
      `CHK("rresp", (i < 10) ? RESP_OKAY : RESP_SLVERR, rsp);
      `CHK("rdata", (i < 6) ? TD[i] : 32'h0, rd);
    end
    waitTick();
    wr(OFS_YEAR_LOAD, 32'h0000_00FF);
    wr(OFS_RT_LOAD, 32'h0000_0055);
    wr(OFS_YEAR_COUNT, 32'h0);
    rdChk(OFS_CTRL_STATUS, 32'h0001_0002);
    waitTick();
    rdChk(OFS_CTRL_STATUS, 32'h0);
    rdChk(OFS_YEAR_COUNT, 32'h0000_00FF);
    rdChk(OFS_RT_COUNT, 32'h0000_0055);
    wr(OFS_YEAR_MATCH_0, 32'h0000_0101);
    wr(OFS_YEAR_MATCH_1, 32'h0000_0102);
    wr(OFS_YEAR_MATCH_2, 32'h0000_0102);
    wr(OFS_RT_MATCH_0, 32'h0000_0057);
    for (int k = 0; k < 4; k++)
    begin
      waitTick();
      `CHK("match", MX[k], mt);
      `CHK("wake", MX[k][2], wk);
      `CHK("rt events", {MR[k], 1'b1}, rtSeen);
    end
    wr(OFS_YEAR_TRIM, 32'h0000_0002);
    rdChk(OFS_YEAR_TRIM, 32'h0000_0002);
    waitTick();
    e0 = slowEdges;
    waitTick();
    `CHK("edges per tick", 32'h3, slowEdges - e0);
    wr(OFS_YEAR_TRIM, 32'h0);
    waitTick();
    sleep <= 1'b1;
    axiRead(OFS_RT_COUNT);
    c0 = rd;
    axiRead(OFS_YEAR_COUNT);
    y0 = rd;
    wr(OFS_RT_MATCH_1, 32'h0000_0001);
    repeat (3)
    begin
      waitTick();
      `CHK("rt asleep", 4'h0, rtSeen);
    end
    rdChk(OFS_RT_COUNT, c0);
    rdChk(OFS_YEAR_COUNT, y0 + 32'h3);
    rdChk(OFS_CTRL_STATUS, 32'h0004_0000);
    rdChk(OFS_RT_MATCH_0, 32'h0000_0057);
    sleep <= 1'b0;
    repeat (2)
    begin
      waitTick();
      `CHK("rt awake", 4'h1, rtSeen);
    end
    rdChk(OFS_RT_COUNT, c0 + 32'h2);
    rdChk(OFS_CTRL_STATUS, 32'h0);
    summarize();
  end
endmodule // yrc_counters_test
